// File: rtl/ts_fifo.sv
// Timestamp FIFO holding captured counter values
`timescale 1ns/1ps
`default_nettype none
module ts_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic push_valid_i,
	input wire logic [WIDTH-1:0] push_data_i,
	output logic push_ready_o,
	input wire logic pop_ready_i,
	output logic pop_valid_o,
	output logic [WIDTH-1:0] pop_data_o,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin
		$error("ts_fifo depth must be a power of two, at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic do_push;
	logic do_pop;

	assign level_o = wr_ptr - rd_ptr;
	assign push_ready_o = (level_o != (AW+1)'(DEPTH));
	assign pop_valid_o = (wr_ptr != rd_ptr);
	assign pop_data_o = mem[rd_ptr[AW-1:0]];
	assign do_push = push_valid_i && push_ready_o;
	assign do_pop = pop_ready_i && pop_valid_o;

	always_ff @(posedge clk_i) begin
		if (do_push)
			mem[wr_ptr[AW-1:0]] <= push_data_i;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: rtl/window_trigger_gate_timestamp.sv
// Window trigger gate engine with timestamp capture and Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
module window_trigger_gate_timestamp #(
	parameter int FIFO_DEPTH = wtg_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire wtg_pkg::sample_t sample_i,
	input wire logic [wtg_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic gate_o,
	output logic armed_o,
	output logic irq_o
);
	import wtg_pkg::*;

	// Refused at elaboration: the FIFO pointers need a power-of-two depth
	if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin
		$error("FIFO_DEPTH must be a power of two, at least 2");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0] mode_reg;
	logic signed [31:0] upper_reg;
	logic signed [31:0] lower_reg;
	logic [15:0] pwidth_reg;
	logic [31:0] ormask_reg;
	logic [2:0] ts_mode_reg;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic running;
	bus_state_t bus_state;
	logic [31:0] next_readdata;
	logic [31:0] pop_hi;
	av_req_t req;
	logic wr_acc;
	logic rd_acc;
	logic [31:0] be_mask;

	assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i,
		writedata: avs_writedata_i};
	// One wait state: the answer is taken on the second edge that sees the request
	assign wr_acc = req.write && bus_state == BUS_ANSWER;
	assign rd_acc = req.read && bus_state == BUS_ANSWER;

	always_comb begin
		for (int i = 0; i < 4; i++)
			be_mask[i*8 +: 8] = {8{avs_byteenable_i[i]}};
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus_state <= BUS_IDLE;
			avs_waitrequest_o <= 1'b1;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					if (req.read || req.write) begin
						bus_state <= BUS_ANSWER;
						avs_waitrequest_o <= 1'b0;
					end
				end
				BUS_ANSWER: begin
					bus_state <= BUS_IDLE;
					avs_waitrequest_o <= 1'b1;
				end
				default: begin
					bus_state <= BUS_IDLE;
					avs_waitrequest_o <= 1'b1;
				end
			endcase
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mode_reg <= MODE_RESET;
			upper_reg <= THRESH_RESET;
			lower_reg <= THRESH_RESET;
			pwidth_reg <= PWIDTH_RESET[15:0];
			ormask_reg <= 32'h00000000;
			ts_mode_reg <= 3'h0;
			irq_mask <= '0;
		end else if (wr_acc) begin
			case (req.address)
				OFF_MODE: mode_reg <= merge(mode_reg, req.writedata, be_mask);
				OFF_UPPER: upper_reg <= merge(upper_reg, req.writedata, be_mask);
				OFF_LOWER: lower_reg <= merge(lower_reg, req.writedata, be_mask);
				OFF_PWIDTH: pwidth_reg <= 16'(merge({16'h0000, pwidth_reg}, req.writedata,
					be_mask));
				OFF_ORMASK: ormask_reg <= merge(ormask_reg, req.writedata, be_mask);
				OFF_TS_CMD: ts_mode_reg <= {req.writedata[TS_STARTRESET_BIT],
					req.writedata[TS_STANDARD_BIT], 1'b0};
				OFF_IRQ_MASK: irq_mask <= req.writedata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Card start and stop, timestamp reset
	logic start_cmd;
	logic ts_clear;
	assign start_cmd = wr_acc && req.address == OFF_CTRL && req.writedata[CTRL_START_BIT];
	assign ts_clear = (wr_acc && req.address == OFF_TS_CMD && req.writedata[TS_RESET_BIT])
		|| (start_cmd && ts_mode_reg[TS_STARTRESET_BIT]);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			running <= 1'b0;
		else if (start_cmd)
			running <= 1'b1;
		else if (wr_acc && req.address == OFF_CTRL && req.writedata[CTRL_STOP_BIT])
			running <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timestamp counter
	logic [TS_W-1:0] ts_count;
	// Counts valid samples only, so stamps stay in sample units
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			ts_count <= '0;
		else if (ts_clear)
			ts_count <= '0;
		else if (sample_i.valid)
			ts_count <= ts_count + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Window compare and gate engine
	logic inside_now;
	logic inside_prev;
	logic have_prev;
	logic [15:0] dur_count;
	logic dur_run;
	logic enabled;
	logic next_gate;
	logic entered;
	logic left;
	logic signed [31:0] samp_ext;

	assign samp_ext = 32'(sample_i.data);
	assign inside_now = (samp_ext >= lower_reg) && (samp_ext <= upper_reg);
	assign enabled = running && ormask_reg[ORMASK_CH0_BIT];
	// Edges need a sample before them, so the first sample after start never counts as one
	assign entered = have_prev && !inside_prev && inside_now;
	assign left = have_prev && inside_prev && !inside_now;

	always_comb begin
		next_gate = gate_o;
		case (mode_reg)
			MODE_WINENTER: begin
				if (entered)
					next_gate = 1'b1;
				else if (left)
					next_gate = 1'b0;
			end
			MODE_WINLEAVE: begin
				if (left)
					next_gate = 1'b1;
				else if (entered)
					next_gate = 1'b0;
			end
			MODE_INWIN: next_gate = inside_now;
			MODE_OUTWIN: next_gate = !inside_now;
			MODE_LONG_IN: begin
				if (!inside_now)
					next_gate = 1'b0;
				else if (dur_run && dur_count == pwidth_reg - 16'h0001)
					next_gate = 1'b1;
			end
			MODE_LONG_OUT: begin
				if (inside_now)
					next_gate = 1'b0;
				else if (dur_run && dur_count == pwidth_reg - 16'h0001)
					next_gate = 1'b1;
			end
			default: next_gate = 1'b0;
		endcase
		if (!enabled)
			next_gate = 1'b0;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			inside_prev <= 1'b0;
			have_prev <= 1'b0;
		end else if (!running) begin
			have_prev <= 1'b0;
		end else if (sample_i.valid) begin
			inside_prev <= inside_now;
			have_prev <= 1'b1;
		end
	end

	// Duration counter restarts on every qualifying transition; pwidth under 2 is undefined
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dur_count <= 16'h0000;
			dur_run <= 1'b0;
		end else if (!enabled) begin
			dur_run <= 1'b0;
		end else if (sample_i.valid) begin
			if ((mode_reg == MODE_LONG_IN && entered) ||
				(mode_reg == MODE_LONG_OUT && left)) begin
				dur_count <= 16'h0001;
				dur_run <= 1'b1;
			end else if (dur_run) begin
				if ((mode_reg == MODE_LONG_IN && !inside_now) ||
					(mode_reg == MODE_LONG_OUT && inside_now) ||
					dur_count == pwidth_reg - 16'h0001)
					dur_run <= 1'b0;
				else
					dur_count <= dur_count + 16'h0001;
			end
		end
	end

	// Gate drops at once when disarmed; that close is still stamped
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			gate_o <= 1'b0;
		else if (!enabled)
			gate_o <= 1'b0;
		else if (sample_i.valid)
			gate_o <= next_gate;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			armed_o <= 1'b0;
		else
			armed_o <= enabled;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timestamp capture
	logic gate_open_ev;
	logic gate_close_ev;
	logic push_ready;
	logic pop_valid;
	logic [TS_W-1:0] pop_data;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	logic pop_req;
	logic pop_seen;

	assign gate_open_ev = enabled && sample_i.valid && next_gate && !gate_o;
	assign gate_close_ev = gate_o && (!enabled || (sample_i.valid && !next_gate));
	assign pop_req = rd_acc && req.address == OFF_TS_POP && pop_seen;

	// Pop only an entry that the read returned; a stamp landing mid-read stays queued
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			pop_seen <= 1'b0;
		else if (req.read && bus_state == BUS_IDLE)
			pop_seen <= pop_valid;
	end

	ts_fifo #(
		.WIDTH(TS_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.push_valid_i(gate_open_ev || gate_close_ev),
		.push_data_i(ts_count),
		.push_ready_o(push_ready),
		.pop_ready_i(pop_req),
		.pop_valid_o(pop_valid),
		.pop_data_o(pop_data),
		.level_o(fifo_level)
	);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			pop_hi <= 32'h00000000;
		else if (rd_acc && req.address == OFF_TS_POP)
			pop_hi <= pop_req ? pop_data[63:32] : 32'h00000000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts: set wins over a write-one clear
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	assign irq_set = {(gate_open_ev || gate_close_ev) && !push_ready, gate_close_ev,
		gate_open_ev};
	assign irq_clr = (wr_acc && req.address == OFF_IRQ_STAT) ? req.writedata[IRQ_W-1:0] : '0;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_stat <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			irq_o <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data
	// Latched at the request edge, so it stands through the answer cycle
	always_comb begin
		case (req.address)
			OFF_MODE: next_readdata = mode_reg;
			OFF_UPPER: next_readdata = upper_reg;
			OFF_LOWER: next_readdata = lower_reg;
			OFF_PWIDTH: next_readdata = {16'h0000, pwidth_reg};
			OFF_ORMASK: next_readdata = ormask_reg;
			OFF_TS_CMD: next_readdata = {29'h0, ts_mode_reg};
			OFF_CTRL: next_readdata = {31'h0, running};
			OFF_STATUS: next_readdata = {16'h0, 8'(fifo_level), 5'h0, pop_valid, armed_o,
				gate_o};
			OFF_IRQ_STAT: next_readdata = {29'h0, irq_stat};
			OFF_IRQ_MASK: next_readdata = {29'h0, irq_mask};
			OFF_TS_LO: next_readdata = ts_count[31:0];
			OFF_TS_HI: next_readdata = ts_count[63:32];
			OFF_TS_POP: next_readdata = pop_valid ? pop_data[31:0] : 32'h00000000;
			OFF_TS_POP + 18'h1: next_readdata = pop_hi;
			default: next_readdata = UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			avs_readdata_o <= 32'h00000000;
		else if (req.read && bus_state == BUS_IDLE)
			avs_readdata_o <= next_readdata;
	end
endmodule
`default_nettype wire

// File: rtl/wtg_pkg.sv
// Package: register map, mode codes, field layouts and carriers for the window trigger block
package wtg_pkg;
	localparam int ADDR_W = 18;
	localparam logic [ADDR_W-1:0] OFF_MODE = 18'h09EA2;
	localparam logic [ADDR_W-1:0] OFF_UPPER = 18'h0A4D8;
	localparam logic [ADDR_W-1:0] OFF_LOWER = 18'h0A53C;
	localparam logic [ADDR_W-1:0] OFF_PWIDTH = 18'h0AC45;
	localparam logic [ADDR_W-1:0] OFF_ORMASK = 18'h09E0C;
	localparam logic [ADDR_W-1:0] OFF_TS_CMD = 18'h0B7C8;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 18'h0B7D0;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 18'h0B7D1;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 18'h0B7D2;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 18'h0B7D3;
	localparam logic [ADDR_W-1:0] OFF_TS_LO = 18'h0B7D4;
	localparam logic [ADDR_W-1:0] OFF_TS_HI = 18'h0B7D5;
	localparam logic [ADDR_W-1:0] OFF_TS_POP = 18'h0B7D6;
	localparam logic [31:0] MODE_WINENTER = 32'h00000020;
	localparam logic [31:0] MODE_WINLEAVE = 32'h00000040;
	localparam logic [31:0] MODE_INWIN = 32'h00000080;
	localparam logic [31:0] MODE_OUTWIN = 32'h00000100;
	localparam logic [31:0] MODE_LONG_IN = 32'h04000020;
	localparam logic [31:0] MODE_LONG_OUT = 32'h04000040;
	localparam logic [31:0] MODE_RESET = 32'h00000000;
	localparam logic [31:0] THRESH_RESET = 32'h00000000;
	localparam logic [31:0] PWIDTH_RESET = 32'h00000002;
	localparam int ORMASK_CH0_BIT = 0;
	localparam int TS_RESET_BIT = 0;
	localparam int TS_STANDARD_BIT = 1;
	localparam int TS_STARTRESET_BIT = 2;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int IRQ_OPEN_BIT = 0;
	localparam int IRQ_CLOSE_BIT = 1;
	localparam int IRQ_OVF_BIT = 2;
	localparam int IRQ_W = 3;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
	localparam int TS_W = 64;
	localparam int FIFO_DEPTH = 16;

	typedef struct packed {
		logic valid;
		logic signed [15:0] data;
	} sample_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} av_req_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_t;
endpackage

// File: tb/sample_source.sv
// Partner: stream of digitised samples for one channel
`timescale 1ns/1ps
`default_nettype none
module sample_source (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic go_i,
	input wire logic signed [15:0] level_i,
	output var wtg_pkg::sample_t sample_o
);
	import wtg_pkg::*;
	logic signed [15:0] last;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			last <= 16'sh0000;
		end else begin
			last <= sample_o.data;
		end
	end
	// Idle data toggles, so a stale value never passes for a sample
	always_comb begin
		sample_o.valid = go_i;
		sample_o.data = go_i ? level_i : ~last;
	end
endmodule
`default_nettype wire

// File: tb/window_trigger_gate_timestamp_tb_top.sv
// Testbench: registers, window modes, timestamps and interrupt
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module window_trigger_gate_timestamp_tb_top;
	import wtg_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	sample_t sample;
	logic go = 1'b0;
	logic signed [15:0] level = 16'sh0000;
	logic [ADDR_W-1:0] address = 18'h00000;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic waitreq, gate, armed, irq;
	logic [31:0] q;
	int mismatches = 0;
	int total_checks = 0;
	always #20 clk_i = ~clk_i;
	sample_source i_src (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .level_i(level),
		.sample_o(sample));
	window_trigger_gate_timestamp #(.FIFO_DEPTH(16)) i_dut (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .sample_i(sample), .avs_address_i(address), .avs_read_i(rd_en),
		.avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .gate_o(gate), .armed_o(armed),
		.irq_o(irq));
////////////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		address <= a;
		wr_en <= w;
		rd_en <= !w;
		wdata <= d;
		// Request holds until an edge samples waitrequest low; data taken there
		do begin
			@(posedge clk_i);
			n++;
		end while (waitreq !== 1'b0 && n < 100);
		if (waitreq !== 1'b0) mismatches++;
		q = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask
	task automatic chk_rd(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h00000000);
		`CHK(n, e, q)
	endtask
	task automatic chk_irq(input string n, input logic e);
		repeat (2) @(posedge clk_i);
		#1;
		`CHK(n, e, irq)
	endtask
	// Inside values hit both bounds; outside ones sit one step beyond, except 0x32 far below the lower bound
	function automatic logic signed [15:0] val(input int k, input logic in);
		case (k % 3)
			0: val = in ? 16'sh0064 : 16'sh0063;
			1: val = in ? 16'sh00C8 : 16'sh00C9;
			default: val = in ? 16'sh0096 : 16'sh0032;
		endcase
	endfunction
////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		chk_rd("mode", OFF_MODE, MODE_RESET);
		chk_rd("upper", OFF_UPPER, THRESH_RESET);
		chk_rd("lower", OFF_LOWER, THRESH_RESET);
		chk_rd("pwidth", OFF_PWIDTH, PWIDTH_RESET);
		bus(1'b1, OFF_UPPER, 32'h000000C8);
		bus(1'b1, OFF_LOWER, 32'h00000064);
		bus(1'b1, OFF_PWIDTH, 32'h00000003);
		bus(1'b1, 18'h00001, 32'hFFFFFFFF);
		chk_rd("upper wr", OFF_UPPER, 32'h000000C8);
		chk_rd("lower wr", OFF_LOWER, 32'h00000064);
		chk_rd("unmapped", 18'h00001, UNMAPPED_DATA);
		bus(1'b1, OFF_ORMASK, 32'h00000001);
		bus(1'b1, OFF_TS_CMD, 32'h00000004);
		bus(1'b1, OFF_IRQ_MASK, 32'h00000001);
	endtask
	task automatic t_mode(input string n, input logic [31:0] m, input logic [7:0] inb,
		input logic [7:0] exb);
		logic prev;
		bus(1'b1, OFF_CTRL, 32'h00000002);
		bus(1'b1, OFF_IRQ_STAT, 32'h00000007);
		bus(1'b1, OFF_MODE, m);
		bus(1'b1, OFF_CTRL, 32'h00000001);
		@(posedge clk_i);
		go <= 1'b1;
		level <= val(0, inb[0]);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_i);
			level <= val(k + 1, inb[(k + 1) % 8]);
			if (k == 7) go <= 1'b0;
			#1;
			`CHK(n, exb[k], gate)
		end
		// Counter cleared at start, so stamp equals sample index
		prev = 1'b0;
		for (int k = 0; k < 8; k++) begin
			if (exb[k] !== prev) begin
				chk_rd("stamp lo", OFF_TS_POP, 32'(k));
				chk_rd("stamp hi", 18'h0B7D7, 32'h00000000);
			end
			prev = exb[k];
		end
	endtask
	task automatic t_irq();
		chk_irq("irq set", 1'b1);
		chk_rd("irq stat", OFF_IRQ_STAT, 32'h00000003);
		bus(1'b1, OFF_IRQ_STAT, 32'h00000001);
		chk_irq("irq clr", 1'b0);
		bus(1'b1, OFF_IRQ_MASK, 32'h00000002);
		chk_irq("irq mask", 1'b1);
		bus(1'b1, OFF_IRQ_STAT, 32'h00000002);
		chk_irq("irq clr2", 1'b0);
		chk_rd("fifo empty", OFF_TS_POP, 32'h00000000);
	endtask
	// Counter reset command, standard mode, live readout, status and FIFO overflow
	task automatic t_ts();
		chk_rd("status run", OFF_STATUS, 32'h00000002);
		bus(1'b1, OFF_TS_CMD, 32'h00000005);
		chk_rd("ts cleared", OFF_TS_LO, 32'h00000000);
		@(posedge clk_i);
		go <= 1'b1;
		level <= 16'sh0096;
		repeat (5) @(posedge clk_i);
		go <= 1'b0;
		chk_rd("ts count", OFF_TS_LO, 32'h00000005);
		chk_rd("ts high", OFF_TS_HI, 32'h00000000);
		bus(1'b1, OFF_TS_CMD, 32'h00000002);
		bus(1'b1, OFF_CTRL, 32'h00000001);
		chk_rd("ts kept", OFF_TS_LO, 32'h00000005);
		bus(1'b1, OFF_CTRL, 32'h00000002);
		chk_rd("status stop", OFF_STATUS, 32'h00000000);
		bus(1'b1, OFF_MODE, MODE_INWIN);
		bus(1'b1, OFF_IRQ_STAT, 32'h00000007);
		bus(1'b1, OFF_CTRL, 32'h00000001);
		@(posedge clk_i);
		go <= 1'b1;
		for (int k = 0; k < 18; k++) begin
			level <= k[0] ? 16'sh0032 : 16'sh0096;
			@(posedge clk_i);
		end
		go <= 1'b0;
		chk_rd("overflow", OFF_IRQ_STAT, 32'h00000007);
		chk_rd("fifo full", OFF_STATUS, 32'h00001006);
		chk_irq("irq close", 1'b1);
		chk_rd("first stamp", OFF_TS_POP, 32'h00000005);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_mode("enter", MODE_WINENTER, 8'h0B, 8'h08);
		t_mode("leave", MODE_WINLEAVE, 8'hF4, 8'h08);
		t_mode("inside", MODE_INWIN, 8'h0B, 8'h0B);
		t_mode("outside", MODE_OUTWIN, 8'hF2, 8'h0D);
		t_mode("long in", MODE_LONG_IN, 8'h76, 8'h40);
		t_mode("long out", MODE_LONG_OUT, 8'h89, 8'h40);
		t_irq();
		t_ts();
		tally_and_finish();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// File: tb/wtg_monitor.sv
// Checker: port-level assertions for the window trigger block
`timescale 1ns/1ps
`default_nettype none
module wtg_monitor #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire wtg_pkg::sample_t sample_i,
	input wire logic [wtg_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic gate_o,
	input wire logic armed_o
);
	import wtg_pkg::*;
	localparam logic [ADDR_W-1:0] NO_REG = 18'h00001;
	logic [31:0] mode_q;
	logic bad;
	// Shadow of the mode register, seen only from committed bus writes
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mode_q <= MODE_RESET;
		end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == OFF_MODE) begin
			mode_q <= avs_writedata_i;
		end
	end
	assign bad = !(mode_q inside {MODE_WINENTER, MODE_WINLEAVE, MODE_INWIN, MODE_OUTWIN,
		MODE_LONG_IN, MODE_LONG_OUT});
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
////////////////////////////////////////////////////////////////////////////////
	a_gate_off_unarmed: assert property (!armed_o && !$past(armed_o) |-> !gate_o)
		else $error("gate open while disarmed");
	a_gate_change_cause: assert property ($changed(gate_o) |-> $past(sample_i.valid)
		|| $past(avs_write_i) || $past(avs_write_i, 2)) else $error("gate moved without cause");
	a_gate_rise_sample: assert property ($rose(gate_o) |-> $past(sample_i.valid)
		&& $past(armed_o)) else $error("gate opened without sample");
	a_bad_mode_closed: assert property (bad && $past(bad) |-> !$rose(gate_o))
		else $error("gate opened in unknown mode");
	a_bus_answer_next: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("no answer one cycle after request");
	a_bus_answer_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low two cycles");
	a_bus_idle_wait: assert property (!(avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> avs_waitrequest_o) else $error("answer without request");
	a_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o &&
		avs_address_i == NO_REG |=> avs_readdata_o == 32'h00000000) else $error("unmapped read");
	a_rdata_hold: assert property (!(avs_read_i && avs_waitrequest_o)
		|=> $stable(avs_readdata_o)) else $error("read data changed without read");
endmodule
bind window_trigger_gate_timestamp wtg_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_mon (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sample_i(sample_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .gate_o(gate_o),
	.armed_o(armed_o));
`default_nettype wire
